// *** verilog/sac_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the converter control block
// Assumes: Registers reached over the 8-bit special function register port of the CPU
// Notes: Included by the control module and the core model
//
// Behaviour
// - Each pair bit: 0 two single-ended inputs, 1 even positive, odd negative pair
// - Upper four bits of pair config and channel select ignore writes, read zero
// - Differential results are two's complement; single-ended results are unsigned
// - Channel field 0000-0111 routes input n; top bit set routes temperature sensor
// - Even member of a differential pair selects even minus odd partner
// - Nonzero divider D gives SAR clock of system clock over 2 times D+1
// - Divider zero runs SAR clock at full system clock rate
// - Gain field: 000 x1, 001 x2, 010 x4, 011 x8, 10x x16, 11x x0.5
// - Enable bit high runs converter; low shuts it down, no conversions
// - Track mode 0: track while idle, every trigger converts at once
// - Completion flag set when a conversion completes, not when disable cuts it short; only software clears it
// - Busy reads 1 during the three-clock tracking and conversion, 0 otherwise
// - Busy write of 1 starts conversion only with start source 00; 0 does nothing
// - Start source: 00 software, 01 timer 3, 10 convert pin rise, 11 timer 2
// - Track mode 1, sources 00/01/11: three SAR clocks tracking then conversion
// - Track mode 1, source 10: track while pin low, convert on its rise
// - Window flag set on window match, held until software clears it
// - Right justify: low byte bits 7:0, high 1:0, upper sign or zero
// - Left justify: high byte top eight bits, low 7:6 bottom two, rest zero
// - After reset all inputs single-ended and gain is unity
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ==========================================
// Register addresses
`define SAC_ADDR_PAIR_CFG 8'hBA
`define SAC_ADDR_CHAN_SEL 8'hBB
`define SAC_ADDR_CONV_CFG 8'hBC
`define SAC_ADDR_RES_LO 8'hBE
`define SAC_ADDR_RES_HI 8'hBF
`define SAC_ADDR_CONV_CTL 8'hE8

// ==========================================
// Reset values
`define SAC_RST_PAIR_CFG 8'h00
`define SAC_RST_CHAN_SEL 8'h00
`define SAC_RST_CONV_CFG 8'hF8
`define SAC_RST_CONV_CTL 8'h00

// ==========================================
// Control register bit positions
`define SAC_CTL_ENABLE 7
`define SAC_CTL_TRACK 6
`define SAC_CTL_DONE 5
`define SAC_CTL_BUSY 4
`define SAC_CTL_SRC_HI 3
`define SAC_CTL_SRC_LO 2
`define SAC_CTL_WIN 1
`define SAC_CTL_LJUST 0

// ==========================================
// Timing, in SAR clocks
`define SAC_TRACK_SAR_CLKS 3
`define SAC_CONV_SAR_CLKS 16

`endif

// *** verilog/sac_pkg.sv ***
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the defines header
// Notes: Numbers live in the defines header
package sac_pkg;

	// ==========================================
	// Sequencer states, Gray coded along idle-track-convert
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_TRACK = 2'b01,
		SAC_CONV = 2'b11
	} sac_state_e;

	// ==========================================
	// Start-of-conversion sources
	typedef enum logic [1:0] {
		SAC_SRC_SW = 2'b00,
		SAC_SRC_TMR3 = 2'b01,
		SAC_SRC_PIN = 2'b10,
		SAC_SRC_TMR2 = 2'b11
	} sac_src_e;

endpackage

// *** verilog/sac_ctrl.sv ***
// Purpose: Control of a 10-bit SAR converter: mux setup, SAR clock, start, flags, justification
// Assumes: One system clock; analog core returns its 10-bit code with a done strobe
// Notes: Window limits live elsewhere; only the match strobe enters here
`include "sac_defines.svh"

module sac_ctrl
	import sac_pkg::*;
#(
	parameter int RES_W = 10,
	parameter int DIV_W = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// Start sources
	input wire logic timer3_overflow,
	input wire logic timer2_overflow,
	input wire logic external_convert_start,
	// Window comparator
	input wire logic window_match,
	// Analog core
	output logic converter_enable,
	output logic track_hold_track,
	output logic sar_clk_en,
	output logic conv_start,
	input wire logic [RES_W-1:0] conv_code,
	input wire logic conv_code_valid,
	output logic [3:0] mux_pos_sel,
	output logic [3:0] mux_neg_sel,
	output logic mux_diff,
	output logic [2:0] amp_gain_field,
	// Result and state
	output logic [RES_W-1:0] conv_result,
	output logic conversion_busy
);

	// Result packing and the divider field are laid out for these widths only
	if (RES_W != 10 || DIV_W != 5) begin : g_width_check
		$error("sac_ctrl: only a 10-bit result and 5-bit divider are supported");
	end

	// ==========================================
	// Registers
	logic [3:0] pair_cfg_ff;
	logic [3:0] chan_sel_ff;
	logic [7:0] conv_cfg_ff;
	logic [7:0] res_lo_ff;
	logic [7:0] res_hi_ff;
	logic en_ff;
	logic track_ff;
	logic done_ff;
	logic win_ff;
	logic ljust_ff;
	logic [1:0] src_ff;
	logic wr_ctl;
	logic busy_now;

	assign wr_ctl = sfr_wr && sfr_addr == `SAC_ADDR_CONV_CTL;

	// Only the low nibble of the two mux registers exists; upper bits are dropped on write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) pair_cfg_ff <= 4'h0;
		else if (sfr_wr && sfr_addr == `SAC_ADDR_PAIR_CFG) pair_cfg_ff <= sfr_wdata[3:0];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) chan_sel_ff <= 4'h0;
		else if (sfr_wr && sfr_addr == `SAC_ADDR_CHAN_SEL) chan_sel_ff <= sfr_wdata[3:0];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) conv_cfg_ff <= `SAC_RST_CONV_CFG;
		else if (sfr_wr && sfr_addr == `SAC_ADDR_CONV_CFG) conv_cfg_ff <= sfr_wdata;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_ff <= 1'b0;
			track_ff <= 1'b0;
			src_ff <= 2'b00;
			ljust_ff <= 1'b0;
		end else if (wr_ctl) begin
			en_ff <= sfr_wdata[`SAC_CTL_ENABLE];
			track_ff <= sfr_wdata[`SAC_CTL_TRACK];
			src_ff <= sfr_wdata[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO];
			ljust_ff <= sfr_wdata[`SAC_CTL_LJUST];
		end
	end

	// ==========================================
	// Control fields as they stand once this cycle's write lands, so that a
	// single write can enable, choose the source and start a conversion together
	logic en_now;
	logic track_now;
	logic [1:0] src_now;
	assign en_now = wr_ctl ? sfr_wdata[`SAC_CTL_ENABLE] : en_ff;
	assign track_now = wr_ctl ? sfr_wdata[`SAC_CTL_TRACK] : track_ff;
	assign src_now = wr_ctl ? sfr_wdata[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO] : src_ff;

	// ==========================================
	// Pin synchroniser and edge detect
	logic [2:0] pin_sync_ff;
	logic pin_rise;
	// Bits 0 and 1 are the synchroniser; bit 2 only holds the previous synced level
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) pin_sync_ff <= 3'b000;
		else pin_sync_ff <= {pin_sync_ff[1:0], external_convert_start};
	end
	assign pin_rise = pin_sync_ff[1] && !pin_sync_ff[2];

	// ==========================================
	// SAR clock divider
	logic [5:0] div_cnt_ff;
	logic [5:0] div_last;
	logic sar_tick;
	assign div_last = {conv_cfg_ff[7:3], 1'b1};
	// Zero divider ticks every cycle; otherwise once every 2*(D+1) cycles
	assign sar_tick = (conv_cfg_ff[7:3] == 5'b00000) || (div_cnt_ff == div_last);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) div_cnt_ff <= 6'h00;
		else if (sar_tick || !busy_now) div_cnt_ff <= 6'h00;
		else div_cnt_ff <= div_cnt_ff + 6'h01;
	end
	// Parked at zero while idle, so each conversion begins on a full SAR period.
	// A divider made smaller mid-conversion can let the count pass its end and wrap once.
	assign sar_clk_en = sar_tick && busy_now;

	// ==========================================
	// Start trigger selection
	logic sw_start;
	logic trig;
	// The source field of the same write decides whether a busy write starts
	assign sw_start = wr_ctl && sfr_wdata[`SAC_CTL_BUSY] && sac_src_e'(src_now) == SAC_SRC_SW;
	always_comb begin
		unique case (sac_src_e'(src_now))
			SAC_SRC_SW: trig = sw_start;
			SAC_SRC_TMR3: trig = timer3_overflow;
			SAC_SRC_PIN: trig = pin_rise;
			SAC_SRC_TMR2: trig = timer2_overflow;
		endcase
	end

	// ==========================================
	// Sequencer
	sac_state_e state_ff;
	logic [1:0] trk_cnt_ff;
	logic conv_start_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= SAC_IDLE;
			trk_cnt_ff <= 2'd0;
			conv_start_ff <= 1'b0;
		end else begin
			conv_start_ff <= 1'b0;
			// Clearing the enable cuts a running conversion short without setting the done flag
			if (!en_now) begin
				state_ff <= SAC_IDLE;
			end else begin
				unique case (state_ff)
					SAC_IDLE: if (trig) begin
						// Pin source in low-power mode already tracked while low
						if (track_now && src_now != SAC_SRC_PIN) begin
							state_ff <= SAC_TRACK;
							trk_cnt_ff <= 2'd0;
						end else begin
							state_ff <= SAC_CONV;
							conv_start_ff <= 1'b1;
						end
					end
					SAC_TRACK: if (sar_tick) begin
						if (trk_cnt_ff == 2'(`SAC_TRACK_SAR_CLKS - 1)) begin
							state_ff <= SAC_CONV;
							conv_start_ff <= 1'b1;
						end else begin
							trk_cnt_ff <= trk_cnt_ff + 2'd1;
						end
					end
					SAC_CONV: if (conv_code_valid) state_ff <= SAC_IDLE;
					default: state_ff <= SAC_IDLE;
				endcase
			end
		end
	end
	assign busy_now = state_ff != SAC_IDLE;
	assign conversion_busy = busy_now;
	assign conv_start = conv_start_ff;
	assign converter_enable = en_ff;

	// High lets the track-and-hold follow the selected input
	always_comb begin
		if (!en_ff) track_hold_track = 1'b0;
		else if (state_ff == SAC_TRACK) track_hold_track = 1'b1;
		else if (state_ff == SAC_CONV) track_hold_track = 1'b0;
		else if (!track_ff) track_hold_track = 1'b1;
		else track_hold_track = (src_ff == SAC_SRC_PIN) && !pin_sync_ff[1];
	end

	// ==========================================
	// Flags: a set in the same cycle as a software clear wins
	logic conv_end;
	assign conv_end = state_ff == SAC_CONV && conv_code_valid;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_ff <= 1'b0;
			win_ff <= 1'b0;
		end else begin
			if (conv_end) done_ff <= 1'b1;
			else if (wr_ctl) done_ff <= sfr_wdata[`SAC_CTL_DONE];
			if (window_match) win_ff <= 1'b1;
			else if (wr_ctl) win_ff <= sfr_wdata[`SAC_CTL_WIN];
		end
	end

	// ==========================================
	// Input mux routing
	logic sel_diff;
	logic [3:0] pair_hit;
	// One line per input pair: set when the pair is differential and holds the selected channel
	for (genvar p = 0; p < 4; p++) begin : g_pair
		assign pair_hit[p] = pair_cfg_ff[p] && !chan_sel_ff[3] && chan_sel_ff[2:1] == 2'(p);
	end
	assign sel_diff = |pair_hit;
	always_comb begin
		mux_diff = sel_diff;
		mux_neg_sel = 4'h0;
		if (chan_sel_ff[3]) begin
			mux_pos_sel = 4'h8;
		end else if (sel_diff) begin
			mux_pos_sel = {1'b0, chan_sel_ff[2:1], 1'b0};
			mux_neg_sel = {1'b0, chan_sel_ff[2:1], 1'b1};
		end else begin
			mux_pos_sel = chan_sel_ff;
		end
	end
	// Codes 10x and 11x decoded by the amplifier itself
	assign amp_gain_field = conv_cfg_ff[2:0];

	// ==========================================
	// Result capture and justification
	// Sign handling follows the mux at conversion start, so a mux change mid-conversion cannot mix formats
	logic diff_at_start_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) diff_at_start_ff <= 1'b0;
		else if (conv_start_ff) diff_at_start_ff <= sel_diff;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			conv_result <= '0;
			res_lo_ff <= 8'h00;
			res_hi_ff <= 8'h00;
		end else if (conv_end) begin
			conv_result <= conv_code;
			if (ljust_ff) begin
				res_hi_ff <= conv_code[9:2];
				res_lo_ff <= {conv_code[1:0], 6'b000000};
			end else begin
				res_lo_ff <= conv_code[7:0];
				res_hi_ff <= {{6{diff_at_start_ff & conv_code[9]}}, conv_code[9:8]};
			end
		end else if (sfr_wr && sfr_addr == `SAC_ADDR_RES_LO) begin
			res_lo_ff <= sfr_wdata;
		end else if (sfr_wr && sfr_addr == `SAC_ADDR_RES_HI) begin
			res_hi_ff <= sfr_wdata;
		end
	end

	// ==========================================
	// Read mux: combinational; idle cycles and unmapped addresses read zero
	logic [7:0] ctl_rd;
	always_comb begin
		ctl_rd = 8'h00;
		ctl_rd[`SAC_CTL_ENABLE] = en_ff;
		ctl_rd[`SAC_CTL_TRACK] = track_ff;
		ctl_rd[`SAC_CTL_DONE] = done_ff;
		ctl_rd[`SAC_CTL_BUSY] = busy_now;
		ctl_rd[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO] = src_ff;
		ctl_rd[`SAC_CTL_WIN] = win_ff;
		ctl_rd[`SAC_CTL_LJUST] = ljust_ff;
	end

	always_comb begin
		sfr_rdata = 8'h00;
		if (sfr_rd) begin
			unique case (sfr_addr)
				`SAC_ADDR_PAIR_CFG: sfr_rdata = {4'h0, pair_cfg_ff};
				`SAC_ADDR_CHAN_SEL: sfr_rdata = {4'h0, chan_sel_ff};
				`SAC_ADDR_CONV_CFG: sfr_rdata = conv_cfg_ff;
				`SAC_ADDR_RES_LO: sfr_rdata = res_lo_ff;
				`SAC_ADDR_RES_HI: sfr_rdata = res_hi_ff;
				`SAC_ADDR_CONV_CTL: sfr_rdata = ctl_rd;
				default: sfr_rdata = 8'h00;
			endcase
		end
	end

endmodule

// *** sim/sac_ctrl_props.sv ***
// Purpose: Port-level checks of the converter control block
// Assumes: Divider and start source mirrored from register writes
// Notes: Bound from the bench top file
module sac_ctrl_props
	import sac_pkg::*;
#(parameter int RES_W = 10, parameter int DIV_W = 5) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// Core side
	input wire logic converter_enable,
	input wire logic track_hold_track,
	input wire logic sar_clk_en,
	input wire logic conv_start,
	input wire logic [RES_W-1:0] conv_code,
	input wire logic conv_code_valid,
	input wire logic [3:0] mux_pos_sel,
	input wire logic [3:0] mux_neg_sel,
	input wire logic mux_diff,
	input wire logic [2:0] amp_gain_field,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic conversion_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [DIV_W-1:0] div_ff;
	logic [1:0] src_ff;
	logic [6:0] gap_ff;
	logic [2:0] trk_ff;
	logic seen_ff;
	// ====
	// Mirrors and counters; pin-started tracking has no fixed length, so it is not counted
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_ff <= 5'h1F;
			src_ff <= 2'h0;
			gap_ff <= 7'h00;
			trk_ff <= 3'h0;
			seen_ff <= 1'b0;
		end else begin
			if (sfr_wr && sfr_addr == 8'hBC) div_ff <= sfr_wdata[7:3];
			if (sfr_wr && sfr_addr == 8'hE8) src_ff <= sfr_wdata[3:2];
			gap_ff <= sar_clk_en ? 7'h01 : gap_ff + 7'h01;
			seen_ff <= conversion_busy && (seen_ff || sar_clk_en);
			trk_ff <= !conversion_busy ? 3'h0 : trk_ff + 3'(sar_clk_en && track_hold_track && src_ff != 2'h2);
		end
	end
	property p_upper_zero;
		sfr_rd && (sfr_addr == 8'hBA || sfr_addr == 8'hBB) |-> sfr_rdata[7:4] == 4'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper nibble not zero");
	property p_sw_start;
		sfr_wr && sfr_addr == 8'hE8 && sfr_wdata[7] && sfr_wdata[4] && sfr_wdata[3:2] == 2'h0 && !conversion_busy
			|=> conversion_busy;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("busy write did not start");
	property p_disabled;
		!converter_enable |-> !conversion_busy && !conv_start;
	endproperty
	a_disabled: assert property (p_disabled) else $error("activity while disabled");
	property p_result;
		conv_code_valid && conversion_busy && !track_hold_track |=> !conversion_busy && conv_result == $past(conv_code);
	endproperty
	a_result: assert property (p_result) else $error("result or busy wrong after code");
	property p_gain;
		sfr_wr && sfr_addr == 8'hBC |=> amp_gain_field == $past(sfr_wdata[2:0]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain field not updated");
	property p_temp;
		sfr_rd && sfr_addr == 8'hBB && sfr_rdata[3] |-> mux_pos_sel == 4'h8 && !mux_diff;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature sensor not routed");
	property p_pair;
		mux_diff |-> !mux_pos_sel[0] && mux_neg_sel == mux_pos_sel + 4'h1;
	endproperty
	a_pair: assert property (p_pair) else $error("differential pair wrong");
	property p_sar_period;
		sar_clk_en && seen_ff |-> gap_ff == (div_ff == 5'h00 ? 7'h01 : 7'({div_ff, 1'b0}) + 7'h02);
	endproperty
	a_sar_period: assert property (p_sar_period) else $error("SAR clock period wrong");
	property p_track_len;
		conv_start |-> trk_ff == 3'h0 || trk_ff == 3'h3;
	endproperty
	a_track_len: assert property (p_track_len) else $error("tracking length wrong");
	c_done: cover property ($fell(conversion_busy));
	c_diff: cover property (mux_diff && conv_start);
	c_track: cover property (conv_start && trk_ff == 3'h3);
endmodule

// *** sim/sac_core_model.sv ***
// Purpose: Behavioural SAR core answering conversion starts
// Assumes: One code per conversion, counted in SAR clock ticks
// Notes: Code lines show the inverse outside the valid pulse
`include "sac_defines.svh"
module sac_core_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control side
	input wire logic conv_start,
	input wire logic sar_clk_en,
	input wire logic [9:0] code_in,
	output logic [9:0] conv_code,
	output logic conv_code_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] left_ff;
	logic [9:0] last_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_ff <= 5'h00;
			last_ff <= 10'h000;
			conv_code_valid <= 1'b0;
		end else begin
			conv_code_valid <= 1'b0;
			if (conv_start) left_ff <= 5'(`SAC_CONV_SAR_CLKS);
			else if (sar_clk_en && left_ff != 5'h00) begin
				left_ff <= left_ff - 5'h01;
				conv_code_valid <= left_ff == 5'h01;
				if (left_ff == 5'h01) last_ff <= code_in;
			end
		end
	end
	assign conv_code = conv_code_valid ? last_ff : ~last_ff;
endmodule

// *** sim/sac_ctrl_tb_top.sv ***
// Purpose: Register-level tests of the converter control block
// Assumes: Core model answers after the fixed SAR tick count
// Notes: Conversions after the first use a small divider to keep the run short
module sac_ctrl_tb_top
	import sac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, timer3_overflow = 0, timer2_overflow = 0;
	logic external_convert_start = 0, window_match = 0, converter_enable, track_hold_track, sar_clk_en;
	logic conv_start, conv_code_valid, mux_diff, conversion_busy;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv, ep, ed, cfg;
	logic [9:0] conv_code, conv_result, code_r = 10'h000;
	logic [3:0] mux_pos_sel, mux_neg_sel;
	logic [2:0] amp_gain_field;
	logic [7:0] ra [7] = '{8'hBA, 8'hBB, 8'hBC, 8'hBE, 8'hBF, 8'hE8, 8'hC0};
	logic [7:0] rs [7] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_total = 0, checked = 0, cyc = 0;
	sac_ctrl DUT (.*);
	sac_core_model u_core (.*, .code_in(code_r));
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	// ====
	// Access tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(negedge core_clk);
		rv = sfr_rdata;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	// Trigger 0 is the busy write inside ctl, 1 timer 3, 2 timer 2, 3 pin rise
	task automatic go(input logic [7:0] ctl, input int trig, input logic [9:0] code, input logic [7:0] hi, lo);
		code_r <= code;
		wr(8'hE8, ctl);
		@(posedge core_clk);
		timer3_overflow <= trig == 1;
		timer2_overflow <= trig == 2;
		if (trig == 3) external_convert_start <= 1'b0;
		@(posedge core_clk);
		timer3_overflow <= 1'b0;
		timer2_overflow <= 1'b0;
		if (trig == 3) repeat (4) @(posedge core_clk);
		if (trig == 3) external_convert_start <= 1'b1;
		rv = 8'h00;
		for (int i = 0; i < 1000 && rv[5] !== 1'b1; i++) rd(8'hE8);
		chk("done_busy", 8'h20, rv & 8'h30);
		rd(8'hBF);
		chk("res_hi", hi, rv);
		rd(8'hBE);
		chk("res_lo", lo, rv);
	endtask
	task automatic print_verdict();
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// Sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk("reset_val", rs[i], rv);
		end
		chk("gain_rst", 8'h00, {5'h00, amp_gain_field});
		wr(8'hBA, 8'hFF);
		rd(8'hBA);
		chk("pair_cfg", 8'h0F, rv);
		wr(8'hBB, 8'hFF);
		rd(8'hBB);
		chk("chan_sel", 8'h0F, rv);
		for (int c = 0; c < 2; c++) begin
			cfg = c ? 8'h0A : 8'h05;
			wr(8'hBA, cfg);
			for (int ch = 0; ch < 9; ch++) begin
				wr(8'hBB, 8'(ch));
				@(negedge core_clk);
				ed = {7'h00, ch < 8 && cfg[ch/2]};
				ep = ch > 7 ? 8'h08 : (ed[0] ? 8'(ch & 6) : 8'(ch));
				chk("mux_pos", ep, {4'h0, mux_pos_sel});
				chk("mux_diff", ed, {7'h00, mux_diff});
				if (ed[0]) chk("mux_neg", ep + 8'h01, {4'h0, mux_neg_sel});
			end
		end
		// Reset divider: the slowest SAR clock this system clock can give
		go(8'h90, 0, 10'h2A5, 8'h02, 8'hA5);
		for (int g = 0; g < 8; g++) begin
			wr(8'hBC, {5'h01, 3'(g)});
			@(negedge core_clk);
			chk("gain", 8'(g), {5'h00, amp_gain_field});
		end
		wr(8'hBA, 8'h00);
		wr(8'hBB, 8'h00);
		go(8'h90, 0, 10'h2A5, 8'h02, 8'hA5);
		go(8'h91, 0, 10'h2A5, 8'hA9, 8'h40);
		go(8'h84, 1, 10'h3FF, 8'h03, 8'hFF);
		go(8'h8C, 2, 10'h155, 8'h01, 8'h55);
		go(8'hD0, 0, 10'h0F0, 8'h00, 8'hF0);
		go(8'hC8, 3, 10'h200, 8'h02, 8'h00);
		go(8'h88, 3, 10'h0AA, 8'h00, 8'hAA);
		wr(8'hBC, 8'h00);
		go(8'h90, 0, 10'h001, 8'h00, 8'h01);
		wr(8'hBA, 8'h01);
		go(8'h90, 0, 10'h3FF, 8'hFF, 8'hFF);
		go(8'h91, 0, 10'h200, 8'h80, 8'h00);
		wr(8'hE8, 8'h94);
		rd(8'hE8);
		chk("busy_refused", 8'h84, rv);
		chk("tracking", 8'h01, {7'h00, track_hold_track});
		wr(8'hE8, 8'h10);
		rd(8'hE8);
		chk("disabled", 8'h00, rv);
		@(posedge core_clk);
		window_match <= 1'b1;
		@(posedge core_clk);
		window_match <= 1'b0;
		rd(8'hE8);
		chk("win_set", 8'h02, rv);
		wr(8'hE8, 8'h00);
		rd(8'hE8);
		chk("win_clr", 8'h00, rv);
		print_verdict();
	end
endmodule
bind sac_ctrl sac_ctrl_props #(.RES_W(RES_W), .DIV_W(DIV_W)) u_props (.*);
